// File: logic/sofc_pkg.sv
// Function
// - Output A source: VCO, divided VCO, external.
// - Zero-delay bit feeds phase detector from divider.
// - Mode 0 full chip, mode 1 PLL only.
// - Power codes 0,1,3 ignore chip-enable pin.
// - Power codes 4,6,7 combine with chip-enable pin.
// - Reset bit restores defaults, releases itself automatically.
// - Pump minimum pulse width from eight-entry table.
// - Without force, fastlock engaged only while timeout counter runs.
// - Force with nonzero timeout keeps fastlock engaged.
// - Timeout counter runs two times N reference cycles.
// - Fastlock pump gain is n times unit current.
// - Output divider divides by two times (k+1).
// - Output power codes 0 to 47 valid.
// - Output powerdown bit disables its output.
`default_nettype none
package sofc_pkg;
  localparam int WORD_W = 32;
  localparam logic [3:0] ADDR_MODE_OUTPUT = 4'h5;
  localparam logic [3:0] ADDR_FASTLOCK    = 4'h4;
  localparam logic [3:0] ADDR_DIV_POWER   = 4'h3;
  localparam logic [WORD_W-1:0] MODE_OUTPUT_RESET = 32'h00000000;
  localparam logic [WORD_W-1:0] FASTLOCK_RESET    = 32'h00000000;
  localparam logic [WORD_W-1:0] DIV_POWER_RESET   = 32'h00000000;
  // Field positions of mode_output_control.
  localparam int REG_RESET_BIT   = 4;
  localparam int POWER_STATE_LSB = 5;
  localparam int OP_MODE_LSB     = 8;
  localparam int ZERO_DELAY_BIT  = 10;
  localparam int OUT_A_SRC_LSB   = 11;
  localparam int OUT_B_SRC_LSB   = 13;
  // Field positions of fastlock_pump_control.
  localparam int PULSE_WIDTH_LSB = 4;
  localparam int FL_FORCE_BIT    = 7;
  localparam int FL_TIMEOUT_LSB  = 8;
  localparam int FL_GAIN_LSB     = 20;
  localparam int BLEED_LSB       = 25;
  // Field positions of output_divider_power.
  localparam int OUT_DIV_LSB     = 4;
  localparam int OUT_B_PWR_LSB   = 9;
  localparam int OUT_A_PWR_LSB   = 15;
  localparam int OUT_B_PD_BIT    = 21;
  localparam int OUT_A_PD_BIT    = 22;
  localparam logic [4:0] OUT_DIV_MAX_CODE = 5'h12;
  localparam logic [5:0] OUT_PWR_MAX_CODE = 6'h2F;
  localparam logic [11:0] PULSE_WIDTH_PS [0:7] = '{12'h172, 12'h2F8, 12'h46A, 12'h5B4,
                                                   12'h6EA, 12'h816, 12'h92E, 12'hA28};
  localparam int REF_DIV_DEFAULT = 10;
  typedef enum logic [1:0] {
    SOFC_SRC_VCO  = 2'b00,
    SOFC_SRC_DIV  = 2'b01,
    SOFC_SRC_EXT  = 2'b10,
    SOFC_SRC_RSVD = 2'b11
  } sofc_src_t;
  typedef enum logic [1:0] {
    SOFC_PWR_UP      = 2'b00,
    SOFC_PWR_FULL    = 2'b01,
    SOFC_PWR_PARTIAL = 2'b10
  } sofc_pwr_t;
  typedef enum logic [1:0] {
    SOFC_MODE_FULL_CHIP = 2'b00,
    SOFC_MODE_PLL_ONLY  = 2'b01
  } sofc_mode_t;
endpackage
`default_nettype wire

// File: logic/sofc_word_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sofc_word_if;
  logic [31:0] word;
  logic        valid;
  modport src (output word, output valid);
  modport dst (input word, input valid);
endinterface
`default_nettype wire

// File: logic/sofc_serial_rx.sv
`timescale 1ns/1ps
`default_nettype none
module sofc_serial_rx (
  input  wire logic   clk,
  input  wire logic   rst_b,
  input  wire logic   ser_clk,
  input  wire logic   ser_data,
  input  wire logic   ser_latch,
  sofc_word_if.src    wr
);
  import sofc_pkg::*;

  typedef struct packed {
    logic [2:0]        clk_s;
    logic [1:0]        data_s;
    logic [2:0]        latch_s;
    logic [WORD_W-1:0] shift;
    logic              valid;
  } sofc_rx_state_t;

  sofc_rx_state_t rx_q;
  sofc_rx_state_t rx_d;

  // Pins pass two flops; the third stage only serves the edge detectors.
  always_comb begin
    rx_d         = rx_q;
    rx_d.clk_s   = {rx_q.clk_s[1:0], ser_clk};
    rx_d.data_s  = {rx_q.data_s[0], ser_data};
    rx_d.latch_s = {rx_q.latch_s[1:0], ser_latch};
    rx_d.valid   = 1'b0;
    if (rx_q.clk_s[1] && !rx_q.clk_s[2]) begin
      rx_d.shift = {rx_q.shift[WORD_W-2:0], rx_q.data_s[1]};
    end
    if (rx_q.latch_s[1] && !rx_q.latch_s[2]) begin
      rx_d.valid = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_q <= '0;
    end else begin
      rx_q <= rx_d;
    end
  end

  assign wr.word  = rx_q.shift;
  assign wr.valid = rx_q.valid;
endmodule
`default_nettype wire

// File: logic/sofc_top.sv
`timescale 1ns/1ps
`default_nettype none
module sofc_top #(
  parameter int REF_DIV = sofc_pkg::REF_DIV_DEFAULT
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               ser_clk,
  input  wire logic               ser_data,
  input  wire logic               ser_latch,
  input  wire logic               chip_enable,
  output logic [1:0]              output_a_source_select,
  output logic [1:0]              output_b_source_select,
  output logic                    zero_delay_feedback,
  output logic                    pll_power_on,
  output logic                    vco_power_on,
  output logic                    device_powered_up,
  output logic                    regulators_on,
  output logic                    soft_reset_pulse,
  output logic [11:0]             pump_min_pulse_width_ps,
  output logic                    fastlock_active,
  output logic [4:0]              fastlock_pump_gain,
  output logic [5:0]              pump_bleed_setting,
  output logic [5:0]              output_divide_ratio,
  output logic                    output_divider_valid,
  output logic [5:0]              output_a_power,
  output logic [5:0]              output_b_power,
  output logic                    rf_output_a_enable,
  output logic                    rf_output_b_enable
);
  import sofc_pkg::*;

  // Register images, pin synchroniser, counters and one register per output.
  typedef struct packed {
    logic [WORD_W-1:0] mode_output_control;
    logic [WORD_W-1:0] fastlock_pump_control;
    logic [WORD_W-1:0] output_divider_power;
    logic [1:0]        ce_s;
    logic [15:0]       ref_cnt;
    logic [12:0]       fl_cnt;
    logic [1:0]        a_src;
    logic [1:0]        b_src;
    logic              zero_dly;
    logic              pll_on;
    logic              vco_on;
    logic              dev_up;
    logic              ldo_on;
    logic              soft_rst;
    logic [11:0]       pulse_ps;
    logic              fl_on;
    logic [4:0]        fl_gain;
    logic [5:0]        bleed;
    logic [5:0]        div_ratio;
    logic              div_ok;
    logic [5:0]        a_pwr;
    logic [5:0]        b_pwr;
    logic              a_en;
    logic              b_en;
  } sofc_state_t;

  sofc_state_t st_q;
  sofc_state_t st_d;
  sofc_word_if wr_if ();

  sofc_serial_rx u_rx (
    .clk       (clk),
    .rst_b     (rst_b),
    .ser_clk   (ser_clk),
    .ser_data  (ser_data),
    .ser_latch (ser_latch),
    .wr        (wr_if.src)
  );

  // Reserved codes fall to full powerdown so a stray write cannot leave the part half on.
  function automatic sofc_pwr_t decode_power(input logic [2:0] code, input logic ce);
    case (code)
      3'h0:    decode_power = SOFC_PWR_UP;
      3'h1:    decode_power = SOFC_PWR_FULL;
      3'h3:    decode_power = SOFC_PWR_PARTIAL;
      3'h4:    decode_power = ce ? SOFC_PWR_UP : SOFC_PWR_FULL;
      3'h6:    decode_power = ce ? SOFC_PWR_UP : SOFC_PWR_PARTIAL;
      3'h7:    decode_power = ce ? SOFC_PWR_PARTIAL : SOFC_PWR_FULL;
      default: decode_power = SOFC_PWR_FULL;
    endcase
  endfunction

  logic [3:0]  wr_addr;
  logic [1:0]  op_mode;
  logic [2:0]  pwr_code;
  logic [11:0] fl_timeout;
  logic [4:0]  div_code;
  logic [5:0]  a_pwr_code;
  logic [5:0]  b_pwr_code;
  sofc_pwr_t   pwr_state;
  logic        ref_tick;

  // Per output: enabled unless powered down or its power code is reserved.
  wire logic [1:0] chan_ok;
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    localparam int PWR_LSB = (ch == 0) ? OUT_A_PWR_LSB : OUT_B_PWR_LSB;
    localparam int PD_BIT  = (ch == 0) ? OUT_A_PD_BIT : OUT_B_PD_BIT;
    assign chan_ok[ch] = !st_q.output_divider_power[PD_BIT]
                         && (st_q.output_divider_power[PWR_LSB +: 6] <= OUT_PWR_MAX_CODE);
  end

  always_comb begin
    st_d       = st_q;
    wr_addr    = wr_if.word[3:0];
    // Chip-enable is a pin, so the power decode reads only its second flop.
    st_d.ce_s  = {st_q.ce_s[0], chip_enable};
    st_d.soft_rst = 1'b0;
    // One reference cycle is REF_DIV clocks; the fastlock counter steps once per tick.
    ref_tick   = (st_q.ref_cnt == 16'(REF_DIV - 1));
    st_d.ref_cnt = ref_tick ? 16'h0000 : st_q.ref_cnt + 16'h0001;
    if (ref_tick && st_q.fl_cnt != 13'h0000) begin
      st_d.fl_cnt = st_q.fl_cnt - 13'h0001;
    end
    // A committed word goes to the register its low nibble names; other addresses are dropped.
    if (wr_if.valid) begin
      case (wr_addr)
        ADDR_MODE_OUTPUT: begin
          // The reset bit itself is never stored, which is what releases the reset by itself.
          if (wr_if.word[REG_RESET_BIT]) begin
            st_d.mode_output_control   = MODE_OUTPUT_RESET;
            st_d.fastlock_pump_control = FASTLOCK_RESET;
            st_d.output_divider_power  = DIV_POWER_RESET;
            st_d.fl_cnt                = 13'h0000;
            st_d.soft_rst              = 1'b1;
          end else begin
            st_d.mode_output_control = wr_if.word;
          end
        end
        ADDR_FASTLOCK: begin
          // Every write restarts the timeout, even while an earlier one still runs.
          st_d.fastlock_pump_control = wr_if.word;
          st_d.fl_cnt = {wr_if.word[FL_TIMEOUT_LSB +: 12], 1'b0};
        end
        ADDR_DIV_POWER: begin
          st_d.output_divider_power = wr_if.word;
        end
        default: begin
        end
      endcase
    end

    // Decodes read the stored images, so every output except soft_reset_pulse lags its register by one clock.
    op_mode    = st_q.mode_output_control[OP_MODE_LSB +: 2];
    pwr_code   = st_q.mode_output_control[POWER_STATE_LSB +: 3];
    fl_timeout = st_q.fastlock_pump_control[FL_TIMEOUT_LSB +: 12];
    div_code   = st_q.output_divider_power[OUT_DIV_LSB +: 5];
    a_pwr_code = st_q.output_divider_power[OUT_A_PWR_LSB +: 6];
    b_pwr_code = st_q.output_divider_power[OUT_B_PWR_LSB +: 6];
    pwr_state  = decode_power(pwr_code, st_q.ce_s[1]);
    st_d.a_src    = st_q.mode_output_control[OUT_A_SRC_LSB +: 2];
    st_d.b_src    = st_q.mode_output_control[OUT_B_SRC_LSB +: 2];
    st_d.zero_dly = st_q.mode_output_control[ZERO_DELAY_BIT];
    st_d.dev_up   = (pwr_state == SOFC_PWR_UP);
    st_d.ldo_on   = (pwr_state != SOFC_PWR_FULL);
    // Reserved modes keep both the PLL and the VCO off.
    case (op_mode)
      SOFC_MODE_FULL_CHIP: begin
        st_d.pll_on = st_d.dev_up;
        st_d.vco_on = st_d.dev_up;
      end
      SOFC_MODE_PLL_ONLY: begin
        st_d.pll_on = st_d.dev_up;
        st_d.vco_on = 1'b0;
      end
      default: begin
        st_d.pll_on = 1'b0;
        st_d.vco_on = 1'b0;
      end
    endcase
    st_d.pulse_ps = PULSE_WIDTH_PS[st_q.fastlock_pump_control[PULSE_WIDTH_LSB +: 3]];
    // Force with a zero timeout is an invalid setting and is treated as off.
    if (st_q.fastlock_pump_control[FL_FORCE_BIT]) begin
      st_d.fl_on = (fl_timeout != 12'h000);
    end else begin
      st_d.fl_on = (st_q.fl_cnt != 13'h0000) && (fl_timeout != 12'h000);
    end
    st_d.fl_gain   = st_q.fastlock_pump_control[FL_GAIN_LSB +: 5];
    st_d.bleed     = st_q.fastlock_pump_control[BLEED_LSB +: 6];
    // The sum keeps five bits, so code 31 wraps to a ratio of zero; the valid flag marks it.
    st_d.div_ratio = {div_code + 5'h01, 1'b0};
    st_d.div_ok    = (div_code <= OUT_DIV_MAX_CODE);
    st_d.a_pwr     = a_pwr_code;
    st_d.b_pwr     = b_pwr_code;
    st_d.a_en      = st_d.dev_up && chan_ok[0];
    st_d.b_en      = st_d.dev_up && chan_ok[1];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Every output is a field of the registered state.
  assign output_a_source_select  = st_q.a_src;
  assign output_b_source_select  = st_q.b_src;
  assign zero_delay_feedback     = st_q.zero_dly;
  assign pll_power_on            = st_q.pll_on;
  assign vco_power_on            = st_q.vco_on;
  assign device_powered_up       = st_q.dev_up;
  assign regulators_on           = st_q.ldo_on;
  assign soft_reset_pulse        = st_q.soft_rst;
  assign pump_min_pulse_width_ps = st_q.pulse_ps;
  assign fastlock_active         = st_q.fl_on;
  assign fastlock_pump_gain      = st_q.fl_gain;
  assign pump_bleed_setting      = st_q.bleed;
  assign output_divide_ratio     = st_q.div_ratio;
  assign output_divider_valid    = st_q.div_ok;
  assign output_a_power          = st_q.a_pwr;
  assign output_b_power          = st_q.b_pwr;
  assign rf_output_a_enable      = st_q.a_en;
  assign rf_output_b_enable      = st_q.b_en;
endmodule
`default_nettype wire

// File: sim/sofc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sofc_props #(
  parameter int REF_DIV = 10
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        soft_reset_pulse,
  input wire logic        pll_power_on,
  input wire logic        vco_power_on,
  input wire logic        device_powered_up,
  input wire logic        regulators_on,
  input wire logic [11:0] pump_min_pulse_width_ps,
  input wire logic [4:0]  fastlock_pump_gain,
  input wire logic [5:0]  output_divide_ratio,
  input wire logic        output_divider_valid,
  input wire logic [5:0]  output_a_power,
  input wire logic [5:0]  output_b_power,
  input wire logic        rf_output_a_enable,
  input wire logic        rf_output_b_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_cleared;
    output_a_power == 6'h00 && output_b_power == 6'h00 && fastlock_pump_gain == 5'h00;
  endsequence
  a_vco_needs_pll: assert property (vco_power_on |-> pll_power_on) else $error("vco on without pll");
  a_pll_needs_up: assert property (pll_power_on |-> device_powered_up) else $error("pll on while down");
  a_up_keeps_ldo: assert property (device_powered_up |-> regulators_on) else $error("regulators off");
  a_rf_a_gate: assert property (rf_output_a_enable |-> device_powered_up && output_a_power <= 6'h2F)
    else $error("output a enabled wrongly");
  a_rf_b_gate: assert property (rf_output_b_enable |-> device_powered_up && output_b_power <= 6'h2F)
    else $error("output b enabled wrongly");
  a_div_ratio: assert property (output_divider_valid |-> output_divide_ratio inside {[2:38]}
    && !output_divide_ratio[0]) else $error("divide ratio out of range");
  a_pulse_once: assert property (soft_reset_pulse |=> !soft_reset_pulse) else $error("long reset pulse");
  a_soft_clear: assert property (soft_reset_pulse |-> ##[0:3] s_cleared) else $error("fields not cleared");
  a_width_table: assert property ($past(rst_b) |-> pump_min_pulse_width_ps inside {12'h172, 12'h2F8,
    12'h46A, 12'h5B4, 12'h6EA, 12'h816, 12'h92E, 12'hA28}) else $error("pulse width off table");
endmodule
bind sofc_top sofc_props #(.REF_DIV(REF_DIV)) u_props (.clk, .rst_b, .soft_reset_pulse, .pll_power_on,
  .vco_power_on, .device_powered_up, .regulators_on, .pump_min_pulse_width_ps, .fastlock_pump_gain,
  .output_divide_ratio, .output_divider_valid, .output_a_power, .output_b_power, .rf_output_a_enable,
  .rf_output_b_enable);
`default_nettype wire

// File: sim/sofc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sofc_host_model (
  input  wire logic clk,
  output var logic  ser_clk,
  output var logic  ser_data,
  output var logic  ser_latch
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_latch = 1'b0;
  end
  // Every pin level stands four clocks so the two-flop sync always catches it.
  task automatic hold4();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Whole words only, most significant bit first; the serial clock idles low between frames.
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      ser_data = w[i];
      hold4();
      ser_clk = 1'b1;
      hold4();
      ser_clk = 1'b0;
    end
    ser_data = ~w[0];
    ser_latch = 1'b1;
    hold4();
    ser_latch = 1'b0;
    hold4();
  endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sofc_pkg::*;
  localparam int RD = 2;
  logic clk, rst_b, chip_enable, seen_pulse;
  wire logic ser_clk, ser_data, ser_latch;
  logic [1:0] output_a_source_select, output_b_source_select;
  logic zero_delay_feedback, pll_power_on, vco_power_on, device_powered_up, regulators_on, soft_reset_pulse;
  logic fastlock_active, output_divider_valid, rf_output_a_enable, rf_output_b_enable;
  logic [11:0] pump_min_pulse_width_ps;
  logic [4:0] fastlock_pump_gain;
  logic [5:0] pump_bleed_setting, output_divide_ratio, output_a_power, output_b_power;
  logic [31:0] c3, c4, c5, r;
  logic [53:0] notes[$];
  int n_mismatch = 0, total_checks = 0, fl_cnt = 0;
  int fl_n[2] = '{1, 4095};
  integer seed = 32'h568A;
  event smp;
  wire [53:0] obs = {output_a_source_select, output_b_source_select, zero_delay_feedback, pll_power_on,
    vco_power_on, device_powered_up, regulators_on, pump_min_pulse_width_ps, fastlock_pump_gain, pump_bleed_setting,
    output_divide_ratio, output_divider_valid, output_a_power, output_b_power, rf_output_a_enable,
    rf_output_b_enable, fastlock_active};
  sofc_host_model host (.clk, .ser_clk, .ser_data, .ser_latch);
  sofc_top #(.REF_DIV(RD)) u_dut (.clk, .rst_b, .ser_clk, .ser_data, .ser_latch, .chip_enable,
    .output_a_source_select, .output_b_source_select, .zero_delay_feedback, .pll_power_on, .vco_power_on,
    .device_powered_up, .regulators_on, .soft_reset_pulse, .pump_min_pulse_width_ps, .fastlock_active,
    .fastlock_pump_gain, .pump_bleed_setting, .output_divide_ratio, .output_divider_valid, .output_a_power,
    .output_b_power, .rf_output_a_enable, .rf_output_b_enable);
  function automatic logic [53:0] expect_obs(logic [31:0] a5, a4, a3, logic ce, logic fl);
    logic [2:0] p;
    logic up, full;
    logic [4:0] k;
    int pw [8];
    pw = '{370, 760, 1130, 1460, 1770, 2070, 2350, 2600};
    p = a5[7:5];
    k = a3[8:4];
    up = p == 0 || (ce && (p == 4 || p == 6));
    full = p inside {1, 2, 5} || (!ce && (p == 4 || p == 7));
    return {a5[12:11], a5[14:13], a5[10], up && !a5[9], up && a5[9:8] == 0, up, !full, 12'(pw[a4[6:4]]),
      a4[24:20], a4[30:25], 6'(2 * (k + 1)), k <= 18, a3[20:9], up && !a3[22] && a3[20:15] <= 47,
      up && !a3[21] && a3[14:9] <= 47, fl};
  endfunction
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(logic [31:0] w);
    host.send(w);
    if (w[3:0] == 4'h5 && w[4]) {c3, c4, c5} = '0;
    else if (w[3:0] == 4'h5) c5 = w;
    else if (w[3:0] == 4'h4) c4 = w;
    else if (w[3:0] == 4'h3) c3 = w;
  endtask
  task automatic note(logic fl);
    repeat (8) @(posedge clk);
    #1;
    notes.push_back(expect_obs(c5, c4, c3, chip_enable, fl));
    -> smp;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (fastlock_active === 1'b1) fl_cnt++;
    if (soft_reset_pulse === 1'b1) seen_pulse <= 1'b1;
  end
  initial forever begin
    logic [53:0] e;
    @(smp);
    if (notes.size() == 0) chk("queue", 0, 1);
    else begin
      e = notes.pop_front();
      chk("sources", obs[53:49], e[53:49]);
      chk("power", obs[48:45], e[48:45]);
      chk("pulse width", obs[44:33], e[44:33]);
      chk("gain and bleed", obs[32:22], e[32:22]);
      chk("divider", obs[21:15], e[21:15]);
      chk("rf outputs", obs[14:1], e[14:1]);
      chk("fastlock", obs[0], e[0]);
    end
  end
  initial begin
    #400000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rst_b = 1'b0;
    chip_enable = 1'b0;
    seen_pulse = 1'b0;
    {c3, c4, c5} = '0;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    note(0);
    // Bleed stays at zero or four, and the timeout at zero, so force is never set alone.
    for (int i = 0; i < 16; i++) begin
      chip_enable = i[3];
      r = $random(seed);
      wr({1'b0, 3'h0, i[0], 2'h0, r[4:0], 12'h0, 1'b0, i[2:0], 4'h4});
      wr({9'h0, r[22:9], i[3] ? 5'(18 + i[0]) : r[8:4], 4'h3});
      wr({17'h0, r[14:13], i[1:0], r[10:8], i[2:0], 1'b0, 4'h5});
      wr({r[31:4], i[0] ? 4'h6 : 4'h0});
      note(0);
    end
    foreach (fl_n[j]) begin
      fl_cnt = 0;
      wr({12'h003, 12'(fl_n[j]), 8'h04});
      repeat (2 * fl_n[j] * RD + 20) @(posedge clk);
      chk("fastlock span", 32'(fl_cnt inside {[2 * fl_n[j] * RD - RD : 2 * fl_n[j] * RD + 1]}), 1);
      note(0);
    end
    wr({12'h01F, 12'h002, 8'h84});
    repeat (2 * 2 * RD + 20) @(posedge clk);
    note(1);
    wr(32'h00000015);
    note(0);
    chk("reset pulse", 32'(seen_pulse), 1);
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule
`default_nettype wire
